// [hw/sbi_consts.svh]
// Offsets, field positions, reset values and vector codes of the SPI buffer and interrupt block.
`ifndef SBI_CONSTS_SVH
`define SBI_CONSTS_SVH
`define SBI_OFS_CONTROL 8'h00
`define SBI_OFS_STATUS 8'h08
`define SBI_OFS_RX_BUF 8'h0c
`define SBI_OFS_TX_BUF 8'h0e
`define SBI_OFS_IRQ_ENABLE 8'h2a
`define SBI_OFS_IRQ_FLAGS 8'h2c
`define SBI_OFS_IRQ_VECTOR 8'h2e
`define SBI_CTL_SOFT_RESET_BIT 0
`define SBI_CTL_SEVEN_BIT_BIT 12
`define SBI_STAT_OVERRUN_BIT 5
`define SBI_IRQ_RX_BIT 0
`define SBI_IRQ_TX_BIT 1
`define SBI_CONTROL_RESET 16'h0001
`define SBI_ENABLE_RESET 2'h0
`define SBI_FLAGS_RESET 2'h2
`define SBI_VEC_NONE 16'h0000
`define SBI_VEC_RX 16'h0002
`define SBI_VEC_TX 16'h0004
`endif

// [hw/sbi_pkg.sv]
// Types shared by the SPI buffer and interrupt block.
package sbi_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } sbi_bus_req_s;
    typedef struct packed {
        logic toggle;
        logic [7:0] data;
    } sbi_char_event_s;
endpackage : sbi_pkg

// [hw/sbi_link_side.sv]
// Link-clock half of the block: catches received characters and offers the transmit character.
`timescale 1ns/1ps
module sbi_link_side
    import sbi_pkg::*;
(
    input wire logic link_clk,
    input wire logic hold_reset,
    input wire logic load_toggle,
    input wire logic [7:0] tx_char,
    input wire logic link_rx_valid,
    input wire logic [7:0] link_rx_char,
    input wire logic link_tx_take,
    output sbi_char_event_s rx_event,
    output logic taken_toggle,
    output logic link_tx_ready,
    output logic [7:0] link_tx_char
);
    logic [1:0] rst_sync_reg;
    logic [1:0] rst_sync_next;
    logic [2:0] load_sync_reg;
    logic [2:0] load_sync_next;
    sbi_char_event_s rx_event_reg;
    sbi_char_event_s rx_event_next;
    logic taken_reg;
    logic taken_next;
    logic ready_reg;
    logic ready_next;
    logic [7:0] char_reg;
    logic [7:0] char_next;
    logic link_reset;

    assign link_reset = rst_sync_reg[1];

    always_comb begin
        rst_sync_next = {rst_sync_reg[0], hold_reset};
        load_sync_next = {load_sync_reg[1:0], load_toggle};
        rx_event_next = rx_event_reg;
        taken_next = taken_reg;
        ready_next = ready_reg;
        char_next = char_reg;
        if (link_rx_valid) begin
            rx_event_next.data = link_rx_char;
            rx_event_next.toggle = ~rx_event_reg.toggle;
        end
        // The main side rewrites its copy on each transmit-buffer write, in the same cycle as the load toggle flips, so sampling it here is safe.
        if (load_sync_reg[2] != load_sync_reg[1]) begin
            char_next = tx_char;
            ready_next = 1'b1;
        end else if (link_tx_take && ready_reg) begin
            ready_next = 1'b0;
            taken_next = ~taken_reg;
        end
        if (link_reset) begin
            rx_event_next = '0;
            taken_next = 1'b0;
            ready_next = 1'b0;
            char_next = 8'h00;
        end
        // The toggle chain keeps shifting in reset, so only its first flop ever sees the raw crossing signal.
    end

    always_ff @(posedge link_clk) begin
        rst_sync_reg <= rst_sync_next;
        load_sync_reg <= load_sync_next;
        rx_event_reg <= rx_event_next;
        taken_reg <= taken_next;
        ready_reg <= ready_next;
        char_reg <= char_next;
    end

    assign rx_event = rx_event_reg;
    assign taken_toggle = taken_reg;
    assign link_tx_ready = ready_reg;
    assign link_tx_char = char_reg;
endmodule : sbi_link_side

// [hw/sbi_buffer_irq.sv]
// SPI receive and transmit buffers with interrupt enables, flags and vector.
//
// Functional notes
// R1 - Completed character lands in receive buffer bits 7-0; bits 15-8 read zero.
// R2 - Reading the receive buffer clears the receive flag and error flags.
// R3 - Seven-bit mode stores the received character right-justified with bit 7 zero.
// R4 - Transmit buffer holds the written character until the shifter takes it.
// R5 - Writing the transmit buffer clears the transmit-empty flag.
// R6 - Seven-bit mode keeps transmit bit 7 cleared and never sends it.
// R7 - Enable register: bit 1 transmit, bit 0 receive, both reset zero.
// R8 - Transmit flag is bit 1, set while transmit buffer empty, resets one.
// R9 - Receive flag is bit 0, set on new received character, resets zero.
// R10 - Vector reads 000h none, 002h receive first, 004h transmit empty.
// R11 - Overrun sets when a character arrives before the last was read.
// R12 - Character-length bit zero selects eight bits, one selects seven.
// R13 - Interrupt request is high while any enabled flag is set.
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "sbi_consts.svh"
module sbi_buffer_irq
    import sbi_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input sbi_bus_req_s bus_req,
    output logic [15:0] rd_data,
    output logic irq,
    input wire logic link_clk,
    input wire logic link_rx_valid,
    input wire logic [7:0] link_rx_char,
    input wire logic link_tx_take,
    output logic link_tx_ready,
    output logic [7:0] link_tx_char
);
    logic soft_reset_hold_reg;
    logic soft_reset_hold_next;
    logic seven_bit_select_reg;
    logic seven_bit_select_next;
    logic [7:0] rx_holding_buffer_reg;
    logic [7:0] rx_holding_buffer_next;
    logic [7:0] tx_holding_buffer_reg;
    logic [7:0] tx_holding_buffer_next;
    logic load_toggle_reg;
    logic load_toggle_next;
    logic [1:0] irq_enable_reg;
    logic [1:0] irq_enable_next;
    logic rx_full_flag_reg;
    logic rx_full_flag_next;
    logic tx_empty_flag_reg;
    logic tx_empty_flag_next;
    logic overrun_flag_reg;
    logic overrun_flag_next;
    logic [15:0] rd_data_reg;
    logic [15:0] rd_data_next;
    logic [2:0] rx_sync_reg;
    logic [2:0] rx_sync_next;
    logic [2:0] taken_sync_reg;
    logic [2:0] taken_sync_next;
    logic [7:0] rx_data_sync_reg;
    logic [7:0] rx_data_sync_next;
    sbi_char_event_s rx_event;
    logic taken_toggle;
    logic hold;
    logic rx_arrive;
    logic tx_taken;
    logic wr_ctl;
    logic wr_tx;
    logic wr_ie;
    logic wr_ifg;
    logic rd_rx;
    logic [7:0] rx_char_field;
    logic [7:0] tx_char_field;
    logic [15:0] irq_vector_value;
    logic [15:0] flags_word;
    localparam logic [15:0] control_reset = `SBI_CONTROL_RESET;
    localparam logic [1:0] flags_reset = `SBI_FLAGS_RESET;

    assign hold = reset | soft_reset_hold_reg;

    sbi_link_side u_link (
        .link_clk(link_clk),
        .hold_reset(hold),
        .load_toggle(load_toggle_reg),
        .tx_char(tx_holding_buffer_reg),
        .link_rx_valid(link_rx_valid),
        .link_rx_char(link_rx_char),
        .link_tx_take(link_tx_take),
        .rx_event(rx_event),
        .taken_toggle(taken_toggle),
        .link_tx_ready(link_tx_ready),
        .link_tx_char(link_tx_char)
    );

    // Toggles cross by two flops; the third flop is only for edge detection.
    assign rx_arrive = rx_sync_reg[2] != rx_sync_reg[1];
    assign tx_taken = taken_sync_reg[2] != taken_sync_reg[1];

    assign wr_ctl = bus_req.wr && (bus_req.addr == `SBI_OFS_CONTROL);
    assign wr_tx = bus_req.wr && (bus_req.addr == `SBI_OFS_TX_BUF);
    assign wr_ie = bus_req.wr && (bus_req.addr == `SBI_OFS_IRQ_ENABLE);
    assign wr_ifg = bus_req.wr && (bus_req.addr == `SBI_OFS_IRQ_FLAGS);
    assign rd_rx = bus_req.rd && (bus_req.addr == `SBI_OFS_RX_BUF);

    // The link holds its character steady for a whole character time, so one data sample suffices.
    assign rx_char_field = seven_bit_select_reg ? {1'b0, rx_data_sync_reg[6:0]} : rx_data_sync_reg; // R3 R12
    assign tx_char_field = seven_bit_select_reg ? {1'b0, bus_req.wdata[6:0]} : bus_req.wdata[7:0]; // R6 R12

    always_comb begin
        flags_word = 16'h0000;
        flags_word[`SBI_IRQ_RX_BIT] = rx_full_flag_reg;
        flags_word[`SBI_IRQ_TX_BIT] = tx_empty_flag_reg;
        if (rx_full_flag_reg) begin
            irq_vector_value = `SBI_VEC_RX; // R10
        end else if (tx_empty_flag_reg) begin
            irq_vector_value = `SBI_VEC_TX; // R10
        end else begin
            irq_vector_value = `SBI_VEC_NONE; // R10
        end
    end

    always_comb begin
        soft_reset_hold_next = soft_reset_hold_reg;
        seven_bit_select_next = seven_bit_select_reg;
        irq_enable_next = irq_enable_reg;
        rx_holding_buffer_next = rx_holding_buffer_reg;
        tx_holding_buffer_next = tx_holding_buffer_reg;
        load_toggle_next = load_toggle_reg;
        rx_full_flag_next = rx_full_flag_reg;
        tx_empty_flag_next = tx_empty_flag_reg;
        overrun_flag_next = overrun_flag_reg;
        rx_sync_next = {rx_sync_reg[1:0], rx_event.toggle};
        taken_sync_next = {taken_sync_reg[1:0], taken_toggle};
        rx_data_sync_next = rx_event.data;
        rd_data_next = 16'h0000;
        if (wr_ctl) begin
            soft_reset_hold_next = bus_req.wdata[`SBI_CTL_SOFT_RESET_BIT];
            seven_bit_select_next = bus_req.wdata[`SBI_CTL_SEVEN_BIT_BIT]; // R12
        end
        if (wr_ie) begin
            irq_enable_next = bus_req.wdata[1:0]; // R7
        end
        if (wr_ifg) begin
            rx_full_flag_next = bus_req.wdata[`SBI_IRQ_RX_BIT];
            tx_empty_flag_next = bus_req.wdata[`SBI_IRQ_TX_BIT];
        end
        if (rd_rx) begin
            rx_full_flag_next = 1'b0; // R2
            overrun_flag_next = 1'b0; // R2 R11
        end
        if (wr_tx) begin
            tx_holding_buffer_next = tx_char_field; // R4 R6
            tx_empty_flag_next = 1'b0; // R5
            load_toggle_next = ~load_toggle_reg;
        end else if (tx_taken) begin
            tx_empty_flag_next = 1'b1; // R8
        end
        // Arrival is applied after the read and flag-write clears so that a set in the same cycle as one of them wins.
        if (rx_arrive) begin
            rx_holding_buffer_next = rx_char_field; // R1 R3
            rx_full_flag_next = 1'b1; // R9
            if (rx_full_flag_reg && !rd_rx) begin
                overrun_flag_next = 1'b1; // R11
            end
        end
        if (bus_req.rd) begin
            case (bus_req.addr)
                `SBI_OFS_CONTROL: begin
                    rd_data_next[`SBI_CTL_SOFT_RESET_BIT] = soft_reset_hold_reg;
                    rd_data_next[`SBI_CTL_SEVEN_BIT_BIT] = seven_bit_select_reg;
                end
                `SBI_OFS_STATUS: rd_data_next[`SBI_STAT_OVERRUN_BIT] = overrun_flag_reg;
                `SBI_OFS_RX_BUF: rd_data_next = {8'h00, rx_holding_buffer_reg}; // R1
                `SBI_OFS_TX_BUF: rd_data_next = {8'h00, tx_holding_buffer_reg};
                `SBI_OFS_IRQ_ENABLE: rd_data_next = {14'h0000, irq_enable_reg};
                `SBI_OFS_IRQ_FLAGS: rd_data_next = flags_word;
                `SBI_OFS_IRQ_VECTOR: rd_data_next = irq_vector_value; // R10
                default: rd_data_next = 16'h0000;
            endcase
        end
        // Soft reset holds the data path idle but leaves control and enables alone.
        if (soft_reset_hold_reg) begin
            rx_holding_buffer_next = 8'h00;
            tx_holding_buffer_next = 8'h00;
            rx_full_flag_next = 1'b0; // R9
            tx_empty_flag_next = 1'b1; // R8
            overrun_flag_next = 1'b0;
        end
        if (reset) begin
            soft_reset_hold_next = control_reset[`SBI_CTL_SOFT_RESET_BIT];
            seven_bit_select_next = control_reset[`SBI_CTL_SEVEN_BIT_BIT]; // R12
            irq_enable_next = `SBI_ENABLE_RESET; // R7
            rx_holding_buffer_next = 8'h00;
            tx_holding_buffer_next = 8'h00;
            load_toggle_next = 1'b0;
            rx_full_flag_next = flags_reset[`SBI_IRQ_RX_BIT]; // R9
            tx_empty_flag_next = flags_reset[`SBI_IRQ_TX_BIT]; // R8
            overrun_flag_next = 1'b0;
            rd_data_next = 16'h0000;
        end
    end

    always_ff @(posedge clk) begin
        soft_reset_hold_reg <= soft_reset_hold_next;
        seven_bit_select_reg <= seven_bit_select_next;
        irq_enable_reg <= irq_enable_next;
        rx_holding_buffer_reg <= rx_holding_buffer_next;
        tx_holding_buffer_reg <= tx_holding_buffer_next;
        load_toggle_reg <= load_toggle_next;
        rx_full_flag_reg <= rx_full_flag_next;
        tx_empty_flag_reg <= tx_empty_flag_next;
        overrun_flag_reg <= overrun_flag_next;
        rx_sync_reg <= rx_sync_next;
        taken_sync_reg <= taken_sync_next;
        rx_data_sync_reg <= rx_data_sync_next;
        rd_data_reg <= rd_data_next;
    end

    assign rd_data = rd_data_reg;
    assign irq = (rx_full_flag_reg & irq_enable_reg[`SBI_IRQ_RX_BIT])
               | (tx_empty_flag_reg & irq_enable_reg[`SBI_IRQ_TX_BIT]); // R13
endmodule : sbi_buffer_irq

// [dv/sbi_peer.sv]
// Behavioural serial peer at the link side of the block.
`timescale 1ns/1ps
module sbi_peer (
    input wire logic link_clk,
    output logic link_rx_valid,
    output logic [7:0] link_rx_char,
    output logic link_tx_take,
    input wire logic link_tx_ready,
    input wire logic [7:0] link_tx_char
);
    int slow = 0;
    int wait_cnt = 0;
    logic [7:0] got = 8'h00;
    initial begin
        link_rx_valid = 1'b0;
        link_rx_char = 8'h00;
        link_tx_take = 1'b0;
    end
    // The data line shows the inverse once the pulse is over, so a stale byte cannot pass.
    task send(input logic [7:0] c);
        @(posedge link_clk);
        link_rx_valid <= 1'b1;
        link_rx_char <= c;
        @(posedge link_clk);
        link_rx_valid <= 1'b0;
        link_rx_char <= ~c;
    endtask : send
    always @(posedge link_clk) begin
        link_tx_take <= 1'b0;
        if (link_tx_ready && !link_tx_take) begin
            wait_cnt <= (wait_cnt >= slow) ? 0 : wait_cnt + 1;
            if (wait_cnt >= slow) begin
                link_tx_take <= 1'b1;
                got <= link_tx_char;
            end
        end
    end
endmodule : sbi_peer

// [dv/sbi_buffer_irq_checker.sv]
// Port assertions for the SPI buffer and interrupt block.
`timescale 1ns/1ps
`include "sbi_consts.svh"
module sbi_buffer_irq_checker
    import sbi_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input sbi_bus_req_s bus_req,
    input wire logic [15:0] rd_data,
    input wire logic irq,
    input wire logic link_clk,
    input wire logic link_tx_take,
    input wire logic link_tx_ready,
    input wire logic [7:0] link_tx_char
);
    // Mirrors of the enable and control writes; the design's own copies are not visible here.
    logic [1:0] ie_reg;
    logic [1:0] ie_next;
    logic seven_reg;
    logic seven_next;
    logic run_reg;
    logic run_next;
    always_comb begin
        ie_next = ie_reg;
        seven_next = seven_reg;
        run_next = run_reg;
        if (bus_req.wr && bus_req.addr == `SBI_OFS_IRQ_ENABLE) begin
            ie_next = bus_req.wdata[1:0];
        end
        if (bus_req.wr && bus_req.addr == `SBI_OFS_CONTROL) begin
            seven_next = bus_req.wdata[`SBI_CTL_SEVEN_BIT_BIT];
            run_next = !bus_req.wdata[`SBI_CTL_SOFT_RESET_BIT];
        end
    end
    always_ff @(posedge clk) begin
        ie_reg <= reset ? `SBI_ENABLE_RESET : ie_next;
        seven_reg <= reset ? 1'b0 : seven_next;
        run_reg <= reset ? 1'b0 : run_next;
    end
    chk_read_idle_zero: assert property (@(posedge clk) disable iff (reset)
        !$past(bus_req.rd) |-> rd_data == 16'h0000) else $error("read data not zero outside a read");
    chk_rx_seven_msb: assert property (@(posedge clk) disable iff (reset)
        bus_req.rd && bus_req.addr == `SBI_OFS_RX_BUF && seven_reg |=> !rd_data[7]) else $error("rx msb set");
    chk_vector_codes: assert property (@(posedge clk) disable iff (reset)
        bus_req.rd && bus_req.addr == `SBI_OFS_IRQ_VECTOR |=> rd_data inside {`SBI_VEC_NONE, `SBI_VEC_RX, `SBI_VEC_TX})
        else $error("bad vector code");
    chk_enable_readback: assert property (@(posedge clk) disable iff (reset)
        bus_req.rd && bus_req.addr == `SBI_OFS_IRQ_ENABLE |=> rd_data == {14'h0000, $past(ie_reg)})
        else $error("enable readback wrong");
    chk_irq_masked: assert property (@(posedge clk) disable iff (reset)
        ie_reg == 2'h0 |-> !irq) else $error("irq with all enables off");
    chk_tx_write_clears: assert property (@(posedge clk) disable iff (reset)
        run_reg && ie_reg == 2'h2 && bus_req.wr && bus_req.addr == `SBI_OFS_TX_BUF |=> !irq)
        else $error("tx flag not cleared by write");
    chk_take_drops: assert property (@(posedge link_clk) disable iff (reset)
        link_tx_ready && link_tx_take |=> !link_tx_ready) else $error("ready kept after take");
    chk_offer_stands: assert property (@(posedge link_clk) disable iff (reset)
        link_tx_ready && !link_tx_take |=> link_tx_ready && $stable(link_tx_char)) else $error("offer changed");
    chk_tx_seven_msb: assert property (@(posedge link_clk) disable iff (reset)
        link_tx_ready && seven_reg |-> !link_tx_char[7]) else $error("tx msb offered");
endmodule : sbi_buffer_irq_checker
bind sbi_buffer_irq sbi_buffer_irq_checker chk_i (.clk(clk), .reset(reset), .bus_req(bus_req), .rd_data(rd_data),
    .irq(irq), .link_clk(link_clk), .link_tx_take(link_tx_take), .link_tx_ready(link_tx_ready),
    .link_tx_char(link_tx_char));

// [dv/tb.sv]
// Self-checking bench for the SPI buffer and interrupt block.
`timescale 1ns/1ps
`include "sbi_consts.svh"
module tb
    import sbi_pkg::*;
;
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic reset = 1'b1;
    sbi_bus_req_s bus_req = '0;
    logic [15:0] rd_data;
    logic irq;
    logic link_rx_valid;
    logic link_tx_take;
    logic link_tx_ready;
    logic [7:0] link_rx_char;
    logic [7:0] link_tx_char;
    int n_errors = 0;
    int n_tests = 0;
    initial forever #12.5 clk = ~clk;
    initial begin
        #3.3;
        forever #7.5 link_clk = ~link_clk;
    end
    sbi_buffer_irq DUT (.clk(clk), .reset(reset), .bus_req(bus_req), .rd_data(rd_data), .irq(irq),
        .link_clk(link_clk), .link_rx_valid(link_rx_valid), .link_rx_char(link_rx_char),
        .link_tx_take(link_tx_take), .link_tx_ready(link_tx_ready), .link_tx_char(link_tx_char));
    sbi_peer peer (.link_clk(link_clk), .link_rx_valid(link_rx_valid), .link_rx_char(link_rx_char),
        .link_tx_take(link_tx_take), .link_tx_ready(link_tx_ready), .link_tx_char(link_tx_char));
    task check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req.wr <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1;
        check(rd_data, exp);
    endtask : rd
    // Bounded wait, because the link crossing latency is only known to a few cycles.
    task wait_irq(input logic v);
        int i;
        for (i = 0; i < 200 && irq !== v; i++) @(posedge clk);
        #1;
        check({15'h0000, irq}, {15'h0000, v});
    endtask : wait_irq
    task t_reset;
        rd(`SBI_OFS_CONTROL, `SBI_CONTROL_RESET);
        wait_irq(1'b0);
        rd(`SBI_OFS_IRQ_ENABLE, 16'h0000);
        rd(`SBI_OFS_IRQ_FLAGS, 16'h0002);
        rd(`SBI_OFS_RX_BUF, 16'h0000);
        rd(`SBI_OFS_TX_BUF, 16'h0000);
        rd(8'h40, 16'h0000);
        wr(`SBI_OFS_IRQ_VECTOR, 16'h0002);
        rd(`SBI_OFS_IRQ_VECTOR, `SBI_VEC_TX);
        $display("test reset done");
    endtask : t_reset
    task t_tx;
        peer.slow = 12;
        wr(`SBI_OFS_CONTROL, 16'h0000);
        wr(`SBI_OFS_IRQ_ENABLE, 16'h0002);
        wait_irq(1'b1);
        wr(`SBI_OFS_TX_BUF, 16'h00a5);
        rd(`SBI_OFS_TX_BUF, 16'h00a5);
        rd(`SBI_OFS_IRQ_FLAGS, 16'h0000);
        rd(`SBI_OFS_IRQ_VECTOR, `SBI_VEC_NONE);
        wait_irq(1'b1);
        check({8'h00, peer.got}, 16'h00a5);
        $display("test tx done");
    endtask : t_tx
    task t_rx;
        peer.slow = 0;
        wr(`SBI_OFS_IRQ_ENABLE, 16'h0001);
        wait_irq(1'b0);
        peer.send(8'hc3);
        wait_irq(1'b1);
        rd(`SBI_OFS_IRQ_FLAGS, 16'h0003);
        rd(`SBI_OFS_IRQ_VECTOR, `SBI_VEC_RX);
        rd(`SBI_OFS_RX_BUF, 16'h00c3);
        rd(`SBI_OFS_IRQ_FLAGS, 16'h0002);
        $display("test rx done");
    endtask : t_rx
    task t_overrun;
        peer.send(8'h11);
        repeat (12) @(posedge clk);
        peer.send(8'h22);
        repeat (12) @(posedge clk);
        rd(`SBI_OFS_STATUS, 16'h0020);
        rd(`SBI_OFS_RX_BUF, 16'h0022);
        rd(`SBI_OFS_STATUS, 16'h0000);
        $display("test overrun done");
    endtask : t_overrun
    task t_seven;
        wr(`SBI_OFS_CONTROL, 16'h1000);
        wr(`SBI_OFS_IRQ_ENABLE, 16'h0002);
        wr(`SBI_OFS_TX_BUF, 16'h00ff);
        rd(`SBI_OFS_TX_BUF, 16'h007f);
        wait_irq(1'b1);
        check({8'h00, peer.got}, 16'h007f);
        peer.send(8'hff);
        repeat (12) @(posedge clk);
        rd(`SBI_OFS_RX_BUF, 16'h007f);
        wr(`SBI_OFS_IRQ_FLAGS, 16'h0001);
        rd(`SBI_OFS_IRQ_FLAGS, 16'h0001);
        rd(`SBI_OFS_IRQ_VECTOR, `SBI_VEC_RX);
        wait_irq(1'b0);
        $display("test seven done");
    endtask : t_seven
    task stop_test;
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test
    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        t_reset;
        t_tx;
        t_rx;
        t_overrun;
        t_seven;
        stop_test;
    end
    initial begin
        #200000;
        n_errors++;
        stop_test;
    end
endmodule : tb
